/* power_stage_pwm_config_test.sv */
// Self-checking bench for the power stage PWM config block
`timescale 1ns/100ps
`default_nettype none
`include "pspc_consts.svh"

module power_stage_pwm_config_test;
  import pspc_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_d = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] mx;
  logic [15:0] ew;
  logic [3:0] pv;
  logic [11:0] counter = 12'h000;
  logic [1:0] prescale_sel = 2'h0;
  logic [1:0] lvl = 2'h0;
  pspc_core_t cmd = '0;
  pspc_core_t core;
  logic gen_a, gen_b, fast_clock_sel, adc_sync, a, b;
  logic [1:0] clk_divide_log2;
  pspc_cmp_t active_cmp;
  logic [3:0] flank_mod, cmp_match;
  pspc_mode_t ramp_mode;
  pspc_pins_t pins;
  logic [31:0] r = 32'hce56;
  logic [7:0] q[$];
  logic [9:0] ev_tab [4] = '{10'h200, 10'h100, 10'h080, 10'h040};
  int n_errors = 0;
  int samples_checked = 0;

  pspc_top DUT (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .counter,
    .core, .gen_a, .gen_b, .prescale_sel, .fast_clock_sel, .clk_divide_log2, .active_cmp,
    .flank_mod, .ramp_mode, .cmp_match, .pins, .adc_sync);
  pspc_far_end far_end (.sys_clk, .rst, .cmd, .lvl, .core, .gen_a, .gen_b);

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    $display("compares %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Expected read data waits in the queue for the watcher
  task automatic rd(input logic [3:0] ad, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic wcmp(input int k, input logic [7:0] h, input logic [7:0] l);
    wr(4'(3 + 2 * k), h);
    wr(4'(2 + 2 * k), l);
  endtask : wcmp

  task automatic syn(input logic [1:0] m, input logic [1:0] c);
    wr(`PSPC_OFS_MAIN, {3'b000, m, 3'b100});
    wr(`PSPC_OFS_ROUTE, {2'b00, c, 4'hf});
  endtask : syn

  // Core event lasts one cycle; sync pulse is looked at one cycle after it
  task automatic ev(input logic [9:0] v, input logic e);
    @(posedge sys_clk);
    cmd <= v;
    @(posedge sys_clk);
    cmd <= '0;
    @(posedge sys_clk);
    #1 chk("adc_sync", adc_sync, e);
  endtask : ev

  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk("reg_rdata", reg_rdata, q.pop_front());
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    n_errors++;
    final_report();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(1);
    chk("pins.enable", pins.enable, 4'hf);
    chk("active_cmp", active_cmp, 64'h0);
    rd(`PSPC_OFS_ROUTE, 8'h00);
    rd(`PSPC_OFS_MAIN, 8'h00);
    rd(4'hc, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = xs(r);
      @(posedge sys_clk);
      lvl <= r[9:8];
      prescale_sel <= r[11:10];
      wr(`PSPC_OFS_ROUTE, r[7:0]);
      wr(`PSPC_OFS_MAIN, {3'b000, r[13:12], r[14], r[15], 1'b0});
      rd(`PSPC_OFS_ROUTE, r[7:0]);
      rd(`PSPC_OFS_MAIN, {3'b000, r[13:12], r[14], r[15], 1'b0});
      cyc(3);
      a = r[9] ~^ r[14];
      b = r[8] ~^ r[14];
      chk("pins.enable", pins.enable, {~r[3:0]});
      pv = {r[7] ? a : b, b, r[6] ? b : a, a};
      chk("pins.value", pins.value & r[3:0], pv & r[3:0]);
      chk("fast_clock_sel", fast_clock_sel, r[15]);
      chk("ramp_mode", ramp_mode, r[13:12]);
      chk("clk_divide_log2", clk_divide_log2, r[11:10]);
    end
    wr(`PSPC_OFS_MAIN, 8'h00);
    for (int k = 0; k < 4; k++) begin
      r = xs(r);
      wcmp(k, r[7:0], r[15:8]);
      cyc(3);
      // Reset-B keeps all 16 bits, high byte first; the others keep 12
      ew = k == 3 ? {r[7:0], r[15:8]} : {4'h0, r[3:0], r[15:8]};
      chk("active_cmp", active_cmp[63-16*k -: 16], ew);
      if (k == 3) chk("flank_mod", flank_mod, r[7:4]);
      @(posedge sys_clk);
      counter <= {r[3:0], r[15:8]};
      cyc(3);
      chk("cmp_match", cmp_match[3-k], 1'b1);
    end
    // reset-A kept at one or more for center sync
    wcmp(1, 8'h00, 8'h01);
    for (int c = 0; c < 4; c++) begin
      r = xs(r);
      syn(2'(r % 3), 2'(c));
      ev(ev_tab[c], 1'b1);
      ev(ev_tab[(c + 1) % 4], 1'b0);
    end
    syn(2'h0, 2'h1);
    ev(10'h004, 1'b1);
    syn(2'h0, 2'h3);
    ev(10'h002, 1'b1);
    for (int c = 0; c < 4; c++) begin
      syn(2'h3, 2'(c));
      ev(10'h120, c == 0);
      ev(10'h100, c == 1);
    end
    wr(`PSPC_OFS_MAIN, 8'h00);
    wcmp(0, 8'h01, 8'h23);
    wr(`PSPC_OFS_MAIN, 8'h20);
    wcmp(0, 8'h0a, 8'hbc);
    wr(`PSPC_OFS_ROUTE, 8'h00);
    cyc(3);
    chk("held set_a", active_cmp.set_a, 16'h0123);
    chk("held enable", pins.enable, 4'h0);
    wr(`PSPC_OFS_MAIN, 8'h00);
    cyc(3);
    chk("released set_a", active_cmp.set_a, 16'h0abc);
    chk("released enable", pins.enable, 4'hf);
    wr(`PSPC_OFS_MAIN, 8'h60);
    wcmp(0, 8'h04, 8'h56);
    wcmp(3, 8'h07, 8'h89);
    cyc(3);
    chk("auto set_a", active_cmp.set_a, 16'h0abc);
    ev(10'h001, 1'b0);
    cyc(2);
    chk("auto set_a", active_cmp.set_a, 16'h0456);
    wcmp(0, 8'h0f, 8'hff);
    ev(10'h001, 1'b0);
    cyc(2);
    chk("auto not last", active_cmp.set_a, 16'h0456);
    rd(`PSPC_OFS_STATUS, 8'h01);
    wr(`PSPC_OFS_MAIN, 8'h80);
    wcmp(2, 8'h03, 8'h21);
    wcmp(3, 8'h0f, 8'h65);
    cyc(3);
    chk("half reset_a", active_cmp.reset_a, 16'h0f65);
    chk("half set_a", active_cmp.set_a, 16'h0321);
    r = xs(r);
    mx = r[7:0];
    wr(`PSPC_OFS_ROUTE, 8'h0f);
    wr(`PSPC_OFS_MATRIX, mx);
    rd(`PSPC_OFS_MATRIX, mx);
    wr(`PSPC_OFS_MAIN, 8'h11);
    for (int n = 0; n < 4; n++) begin
      @(posedge sys_clk);
      cmd <= 10'(n << 3);
      cyc(3);
      chk("matrix pins", pins.value, {mx[4+n], mx[4+n], mx[n], mx[n]});
    end
    @(posedge sys_clk);
    cmd <= '0;
    cyc(2);
    final_report();
  end
endmodule : power_stage_pwm_config_test

`default_nettype wire

/* pspc_consts.svh */
// Register offsets, field positions, reset values and widths of the power stage PWM config
`ifndef PSPC_CONSTS_SVH
`define PSPC_CONSTS_SVH
`define PSPC_ADDR_W 4
`define PSPC_OFS_ROUTE 4'h0
`define PSPC_OFS_MAIN 4'h1
`define PSPC_OFS_SA_LO 4'h2
`define PSPC_OFS_SA_HI 4'h3
`define PSPC_OFS_RA_LO 4'h4
`define PSPC_OFS_RA_HI 4'h5
`define PSPC_OFS_SB_LO 4'h6
`define PSPC_OFS_SB_HI 4'h7
`define PSPC_OFS_RB_LO 4'h8
`define PSPC_OFS_RB_HI 4'h9
`define PSPC_OFS_MATRIX 4'ha
`define PSPC_OFS_STATUS 4'hb
`define PSPC_ROUTE_RST 8'h00
`define PSPC_MAIN_RST 8'h00
`define PSPC_CMP_RST 16'h0000
`define PSPC_CMP_W 12
`define PSPC_BIT_D_SRC 7
`define PSPC_BIT_C_SRC 6
`define PSPC_BIT_D_EN 3
`define PSPC_BIT_B_EN 2
`define PSPC_BIT_C_EN 1
`define PSPC_BIT_A_EN 0
`define PSPC_BIT_HALF 7
`define PSPC_BIT_AUTO 6
`define PSPC_BIT_MANUAL 5
`define PSPC_BIT_POL 2
`define PSPC_BIT_CLK 1
`define PSPC_BIT_MATRIX 0
`endif

/* pspc_far_end.sv */
// Stand-in for the counter core and the raw waveform generators facing the config block
`timescale 1ns/100ps
`default_nettype none

module pspc_far_end (
  input wire logic sys_clk,
  input wire logic rst,
  input wire pspc_pkg::pspc_core_t cmd,
  input wire logic [1:0] lvl,
  output pspc_pkg::pspc_core_t core,
  output logic gen_a,
  output logic gen_b
);
  import pspc_pkg::*;
  // ************************************************************
  // Core events
  // ************************************************************
  // Events launch on a clock edge, as a real counter makes them
  always_ff @(posedge sys_clk) begin
    core <= rst ? '0 : cmd;
    gen_a <= lvl[1];
    gen_b <= lvl[0];
  end
endmodule : pspc_far_end

`default_nettype wire

/* pspc_pkg.sv */
// Types shared by the power stage PWM config block
package pspc_pkg;
  typedef enum logic [1:0] {
    PSPC_ONE_RAMP = 2'h0,
    PSPC_TWO_RAMP = 2'h1,
    PSPC_FOUR_RAMP = 2'h2,
    PSPC_CENTER = 2'h3
  } pspc_mode_t;

  typedef struct packed {
    logic d_src;
    logic c_src;
    logic [1:0] sync_sel;
    logic d_en;
    logic b_en;
    logic c_en;
    logic a_en;
  } pspc_route_t;

  typedef struct packed {
    logic half_duty;
    logic auto_hold;
    logic manual_hold;
    pspc_mode_t mode;
    logic polarity;
    logic clk_sel;
    logic matrix_en;
  } pspc_main_t;

  typedef struct packed {
    logic [15:0] set_a;
    logic [15:0] reset_a;
    logic [15:0] set_b;
    logic [15:0] reset_b;
  } pspc_cmp_t;

  // Core status seen from the counter: matches, direction, ramp number, fault hooks
  typedef struct packed {
    logic match_sa;
    logic match_ra;
    logic match_sb;
    logic match_rb;
    logic count_down;
    logic [1:0] ramp_num;
    logic fault_a;
    logic fault_b;
    logic cycle_end;
  } pspc_core_t;

  // Pin drive bundle: value and enable per pin
  typedef struct packed {
    logic [3:0] value;
    logic [3:0] enable;
  } pspc_pins_t;
endpackage : pspc_pkg

/* pspc_top.sv */
// Power stage PWM configuration, update hold and output routing
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "pspc_consts.svh"

module pspc_top #(
  parameter int CMP_W = `PSPC_CMP_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [`PSPC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [11:0] counter,
  input wire pspc_pkg::pspc_core_t core,
  input wire logic gen_a,
  input wire logic gen_b,
  input wire logic [1:0] prescale_sel,
  output logic fast_clock_sel,
  output logic [1:0] clk_divide_log2,
  output pspc_pkg::pspc_cmp_t active_cmp,
  output logic [3:0] flank_mod,
  output pspc_pkg::pspc_mode_t ramp_mode,
  output logic [3:0] cmp_match,
  output pspc_pkg::pspc_pins_t pins,
  output logic adc_sync
);
  import pspc_pkg::*;

  // ****************************************
  // Register file
  // ****************************************
  pspc_route_t route_shadow;
  pspc_route_t route_live;
  pspc_main_t main_cfg;
  pspc_cmp_t cmp_shadow;
  logic [7:0] matrix_shadow;
  logic [7:0] matrix_live;
  logic [7:0] high_latch;
  logic rb_last;
  logic pending;
  logic manual_q;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = reg_wr && (a == o);
  endfunction : hit

  wire wr_route = hit(reg_addr, `PSPC_OFS_ROUTE);
  wire wr_main = hit(reg_addr, `PSPC_OFS_MAIN);
  wire wr_sa = hit(reg_addr, `PSPC_OFS_SA_LO);
  wire wr_ra = hit(reg_addr, `PSPC_OFS_RA_LO);
  wire wr_sb = hit(reg_addr, `PSPC_OFS_SB_LO);
  wire wr_rb = hit(reg_addr, `PSPC_OFS_RB_LO);
  wire wr_matrix = hit(reg_addr, `PSPC_OFS_MATRIX);
  wire wr_high = hit(reg_addr, `PSPC_OFS_SA_HI) || hit(reg_addr, `PSPC_OFS_RA_HI) ||
                 hit(reg_addr, `PSPC_OFS_SB_HI) || hit(reg_addr, `PSPC_OFS_RB_HI);
  wire wr_any_buf = wr_sa || wr_ra || wr_sb || wr_rb || wr_matrix || wr_route;

  wire [15:0] word_in = {high_latch, reg_wdata};
  wire [15:0] word12 = {4'h0, high_latch[3:0], reg_wdata};

  wire [15:0] next_sa = wr_sa ? word12 : cmp_shadow.set_a;
  wire [15:0] next_ra = wr_ra ? word12 : cmp_shadow.reset_a;
  wire [15:0] next_sb = wr_sb ? word12 : cmp_shadow.set_b;
  wire [15:0] next_rb = wr_rb ? word_in : cmp_shadow.reset_b;
  wire [15:0] half_sb = wr_sb ? word12 : cmp_shadow.set_b;
  pspc_cmp_t next_shadow;
  assign next_shadow.set_b = next_sb;
  assign next_shadow.reset_b = next_rb;
  assign next_shadow.set_a = (main_cfg.half_duty && wr_rb) ? half_sb : next_sa;
  assign next_shadow.reset_a = (main_cfg.half_duty && wr_rb) ? {4'h0, word_in[11:0]} : next_ra;

  wire auto_on = main_cfg.auto_hold;
  wire manual_on = main_cfg.manual_hold && !auto_on;
  // auto transfer at cycle end after reset-B written last
  wire auto_xfer = auto_on && pending && rb_last && core.cycle_end;
  wire manual_xfer = manual_q && !main_cfg.manual_hold && !auto_on;
  wire direct = !auto_on && !manual_on;
  wire do_xfer = auto_xfer || manual_xfer || direct;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      route_shadow <= `PSPC_ROUTE_RST;
      main_cfg <= `PSPC_MAIN_RST;
      cmp_shadow <= {4{`PSPC_CMP_RST}};
      matrix_shadow <= 8'h00;
      high_latch <= 8'h00;
      rb_last <= 1'b0;
      pending <= 1'b0;
      manual_q <= 1'b0;
    end else begin
      if (wr_high) begin
        high_latch <= reg_wdata;
      end
      if (wr_route) begin
        route_shadow <= reg_wdata;
      end
      if (wr_main) begin
        main_cfg <= reg_wdata;
      end
      if (wr_matrix) begin
        matrix_shadow <= reg_wdata;
      end
      cmp_shadow <= next_shadow;
      if (wr_any_buf) begin
        rb_last <= wr_rb;
      end
      // Write during transfer cycle stays pending, set wins
      if (wr_any_buf) begin
        pending <= 1'b1;
      end else if (auto_xfer) begin
        pending <= 1'b0;
      end
      manual_q <= manual_on;
    end
  end

  // ****************************************
  // Live copies used by the generator
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_cmp <= {4{`PSPC_CMP_RST}};
      route_live <= `PSPC_ROUTE_RST;
      matrix_live <= 8'h00;
    end else if (do_xfer) begin
      // Auto mode copies the shadow so writes on the transfer edge are not lost later
      active_cmp <= direct ? next_shadow : cmp_shadow;
      route_live <= direct && wr_route ? pspc_route_t'(reg_wdata) : route_shadow;
      matrix_live <= direct && wr_matrix ? reg_wdata : matrix_shadow;
    end
  end

  // ****************************************
  // Compare, clock and mode outputs
  // ****************************************
  // continuous compare
  wire [3:0] next_match = {counter == active_cmp.set_a[CMP_W-1:0],
                           counter == active_cmp.reset_a[CMP_W-1:0],
                           counter == active_cmp.set_b[CMP_W-1:0],
                           counter == active_cmp.reset_b[CMP_W-1:0]};
  // prescaler exponent per code: 0, 1, 2, 3
  wire [1:0] next_div = prescale_sel;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmp_match <= 4'h0;
      fast_clock_sel <= 1'b0;
      clk_divide_log2 <= 2'h0;
      flank_mod <= 4'h0;
      ramp_mode <= PSPC_ONE_RAMP;
    end else begin
      cmp_match <= next_match;
      fast_clock_sel <= main_cfg.clk_sel;
      clk_divide_log2 <= next_div;
      flank_mod <= active_cmp.reset_b[15:12];
      ramp_mode <= main_cfg.mode;
    end
  end

  // ****************************************
  // Output routing
  // ****************************************
  // polarity; matrix bypasses it; per-ramp values
  wire use_matrix = main_cfg.matrix_en && main_cfg.mode == PSPC_FOUR_RAMP;
  wire wave_a = use_matrix ? matrix_live[core.ramp_num] :
                (main_cfg.polarity ? gen_a : !gen_a);
  wire wave_b = use_matrix ? matrix_live[4 + core.ramp_num] :
                (main_cfg.polarity ? gen_b : !gen_b);
  wire extra_d = route_live.d_src ? wave_a : wave_b;
  wire extra_c = route_live.c_src ? wave_b : wave_a;
  pspc_pins_t next_pins;
  assign next_pins.value = {extra_d, wave_b, extra_c, wave_a};
  assign next_pins.enable = ~{route_live.d_en, route_live.b_en, route_live.c_en, route_live.a_en};

  logic next_sync;
  always_comb begin
    next_sync = 1'b0;
    if (main_cfg.mode == PSPC_CENTER) begin
      unique case (route_live.sync_sel)
        2'h0: next_sync = core.match_ra && core.count_down;
        2'h1: next_sync = core.match_ra && !core.count_down;
        2'h2, 2'h3: next_sync = 1'b0;
      endcase
    end else begin
      unique case (route_live.sync_sel)
        2'h0: next_sync = core.match_sa;
        2'h1: next_sync = core.match_ra || core.fault_a;
        2'h2: next_sync = core.match_sb;
        2'h3: next_sync = core.match_rb || core.fault_b;
      endcase
    end
  end

  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd && reg_addr == `PSPC_OFS_ROUTE) next_rdata = route_shadow;
    if (reg_rd && reg_addr == `PSPC_OFS_MAIN) next_rdata = main_cfg;
    if (reg_rd && reg_addr == `PSPC_OFS_MATRIX) next_rdata = matrix_shadow;
    if (reg_rd && reg_addr == `PSPC_OFS_STATUS) next_rdata = {6'h00, rb_last, pending};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pins <= 8'h0f;
      adc_sync <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      pins <= next_pins;
      adc_sync <= next_sync;
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Duplicates are checked against the pins they copy, not against their own select logic
  a_dup_d_source: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> pins.value[3] == ($past(route_live.d_src) ? pins.value[0] : pins.value[2]))
    else $error("extra D routing wrong");
  a_dup_c_source: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> pins.value[1] == ($past(route_live.c_src) ? pins.value[2] : pins.value[0]))
    else $error("extra C routing wrong");
  a_sync_center_none: assert property (@(posedge sys_clk) disable iff (rst)
    (main_cfg.mode == PSPC_CENTER && route_live.sync_sel[1]) |=> !adc_sync)
    else $error("sync in center mode with no source");
  a_sync_ramp_sa: assert property (@(posedge sys_clk) disable iff (rst)
    (main_cfg.mode != PSPC_CENTER && route_live.sync_sel == 2'h0 && core.match_sa) |=> adc_sync)
    else $error("missing leading edge sync");
  a_pin_a_enable: assert property (@(posedge sys_clk) disable iff (rst)
    !route_live.a_en |=> pins.enable[0]) else $error("pin A driven while disabled");
  a_half_copy_ra: assert property (@(posedge sys_clk) disable iff (rst)
    (main_cfg.half_duty && wr_rb) |=> cmp_shadow.reset_a[11:0] == cmp_shadow.reset_b[11:0])
    else $error("half duty copy missing");
  a_manual_hold_keep: assert property (@(posedge sys_clk) disable iff (rst)
    (manual_on && $stable(main_cfg.manual_hold) && !auto_on) |=> $stable(active_cmp))
    else $error("live compare changed under manual hold");
  a_auto_hold_keep: assert property (@(posedge sys_clk) disable iff (rst)
    (auto_on && !auto_xfer) |=> $stable(active_cmp)) else $error("auto hold leaked");
  a_high_latch_pair: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_rb && !auto_on && !manual_on) |=> active_cmp.reset_b[15:8] == $past(high_latch))
    else $error("high byte not paired");
  a_polarity_low: assert property (@(posedge sys_clk) disable iff (rst)
    (!use_matrix && !main_cfg.polarity) |=> pins.value[0] == !$past(gen_a))
    else $error("polarity wrong");
  c_auto_xfer: cover property (@(posedge sys_clk) disable iff (rst) auto_xfer);
  c_manual_xfer: cover property (@(posedge sys_clk) disable iff (rst) manual_xfer);
  c_center_sync: cover property (@(posedge sys_clk) disable iff (rst)
    main_cfg.mode == PSPC_CENTER ##1 adc_sync);
  c_matrix_use: cover property (@(posedge sys_clk) disable iff (rst) use_matrix);
endmodule : pspc_top

`default_nettype wire
